// >>> hw/ict_sequencer.sv
`timescale 1ns/1ps
module ict_sequencer #(
    parameter int STRETCH_W = ictpkg_pkg::STRETCH_W
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Program memory
    input wire logic [7:0] code_byte_i,
    input wire logic code_valid_i,
    output logic fetch_o,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Datapath side
    output ictpkg_pkg::ict_decode_t decode_o,
    output logic [3:0] state_o,
    output logic [3:0] mcycle_o,
    output logic instr_done_o,
    output logic movx_access_o
);

    ////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        ICT_C1 = 4'b0001,
        ICT_C2 = 4'b0010,
        ICT_C3 = 4'b0100,
        ICT_C4 = 4'b1000
    } ict_state_t;

    // Opcode class to machine cycles; unlisted opcodes take one, or two when two bytes long
    function automatic logic [3:0] ict_cycles(input logic [7:0] op);
        logic [3:0] n;
        n = ictpkg_pkg::MC_ONE;
        if (op[3:0] == 4'h1)
            n = ictpkg_pkg::MC_THREE;
        else if (op == 8'ha4 || op == 8'h84)
            n = ictpkg_pkg::MC_FIVE;
        else if (op == 8'he0 || op == 8'he2 || op == 8'he3 ||
                 op == 8'hf0 || op == 8'hf2 || op == 8'hf3)
            n = ictpkg_pkg::MC_TWO;
        else if (op == 8'h12 || op == 8'h02 || op == 8'h10 || op == 8'h20 ||
                 op == 8'h30 || op == 8'hd5 || op[7:2] == 6'b101101 ||
                 op[7:3] == 5'b10111)
            n = ictpkg_pkg::MC_FOUR;
        else if (op == 8'h80 || op == 8'h40 || op == 8'h50 || op == 8'h60 ||
                 op == 8'h70 || op[7:3] == 5'b11011)
            n = ictpkg_pkg::MC_THREE;
        else if (op == 8'h53 || op == 8'h43 || op == 8'h63 || op == 8'h85 ||
                 op == 8'h75 || op == 8'h90)
            n = ictpkg_pkg::MC_THREE;
        else if (op == 8'h22 || op == 8'h32 || op == 8'h73 || op == 8'h93 ||
                 op == ictpkg_pkg::OP_INC_DPTR || op == ictpkg_pkg::OP_DEC_DPTR ||
                 op == 8'hc0 || op == 8'hd0)
            n = ictpkg_pkg::MC_TWO;
        else if (ict_bytes(op) == 2'd2)
            n = ictpkg_pkg::MC_TWO;
        return n;
    endfunction

    // Instruction length in bytes
    function automatic logic [1:0] ict_bytes(input logic [7:0] op);
        logic [1:0] b;
        b = 2'd1;
        if (op[3:0] == 4'h1 || op == 8'h80 || op == 8'h40 || op == 8'h50 ||
            op == 8'h60 || op == 8'h70 || op[7:3] == 5'b11011)
            b = 2'd2;
        else if (op == 8'h12 || op == 8'h02 || op == 8'h10 || op == 8'h20 ||
                 op == 8'h30 || op == 8'hd5 || op[7:2] == 6'b101101 ||
                 op[7:3] == 5'b10111 || op == 8'h53 || op == 8'h43 ||
                 op == 8'h63 || op == 8'h85 || op == 8'h75 || op == 8'h90)
            b = 2'd3;
        else if (op[3:0] == 4'h5 && op != ictpkg_pkg::OP_DEC_DPTR)
            b = 2'd2;
        else if (op[3:0] == 4'h4 && op[7:4] >= 4'h2 && op[7:4] <= 4'h9 &&
                 op != 8'h84)
            b = 2'd2;
        else if (op[7:3] == 5'b01111 || op[7:3] == 5'b10001 ||
                 op[7:3] == 5'b10101 || op[7:1] == 7'b1010011 ||
                 op[7:1] == 7'b0111011 || op[7:1] == 7'b1000011)
            b = 2'd2;
        else if (op == 8'h52 || op == 8'h42 || op == 8'h62 || op == 8'h82 ||
                 op == 8'hb0 || op == 8'h72 || op == 8'ha0 || op == 8'ha2 ||
                 op == 8'h92 || op == 8'hb2 || op == 8'hc2 || op == 8'hd2 ||
                 op == 8'hc0 || op == 8'hd0)
            b = 2'd2;
        return b;
    endfunction

    // Flag update class
    function automatic ictpkg_pkg::ict_flag_t ict_flags(input logic [7:0] op);
        ictpkg_pkg::ict_flag_t f;
        f = ictpkg_pkg::ICT_FL_NONE;
        if (op[7:4] == 4'h2 || op[7:4] == 4'h3 || op[7:4] == 4'h9)
        begin
            if (op[3:0] >= 4'h4)
                f = ictpkg_pkg::ICT_FL_ARITH;
        end
        if (op == 8'ha4 || op == 8'h84)
            f = ictpkg_pkg::ICT_FL_MULDIV;
        else if (op == 8'hd4)
            f = ictpkg_pkg::ICT_FL_DA;
        else if (op == 8'hd3)
            f = ictpkg_pkg::ICT_FL_CY_SET;
        else if (op == 8'hc3)
            f = ictpkg_pkg::ICT_FL_CY_CLR;
        else if (op == 8'h13 || op == 8'h33 || op == 8'hb3 || op == 8'h82 ||
                 op == 8'hb0 || op == 8'h72 || op == 8'ha0 || op == 8'ha2 ||
                 op[7:2] == 6'b101101 || op[7:3] == 5'b10111)
            f = ictpkg_pkg::ICT_FL_CY_RES;
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Software visible settings
    logic [STRETCH_W-1:0] movx_stretch_field;
    logic pointer_select;
    logic [7:0] clock_control_sfr;
    assign clock_control_sfr = {{(8 - STRETCH_W){1'b0}}, movx_stretch_field};

    wire wr_clock_control = reg_wr_i && reg_addr_i == ictpkg_pkg::ADDR_CLOCK_CONTROL;
    wire wr_psel = reg_wr_i && reg_addr_i == ictpkg_pkg::ADDR_POINTER_SELECT;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            movx_stretch_field <= STRETCH_W'(ictpkg_pkg::CLOCK_CONTROL_RESET);
            pointer_select <= ictpkg_pkg::POINTER_SELECT_RESET[0];
        end
        else
        begin
            if (wr_clock_control)
                movx_stretch_field <= reg_wdata_i[STRETCH_W-1:0];
            if (wr_psel)
                pointer_select <= reg_wdata_i[ictpkg_pkg::POINTER_SELECT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer state
    ict_state_t state;
    ict_state_t next_state;
    ictpkg_pkg::ict_decode_t cur;
    logic [3:0] mc_count;
    logic [3:0] mc_total;

    // Holds in C1 until program memory delivers the opcode
    wire opcode_ok = state == ICT_C1 && code_valid_i && mc_count == 4'h0;
    wire last_state = state == ICT_C4;
    wire last_mc = mc_count + 4'h1 >= mc_total;
    wire finish = last_state && last_mc && mc_count != 4'h0 || last_state && mc_total == 4'h1;
    // Index moves only at the C4 to C1 boundary
    wire [3:0] next_mc_count = last_state ? (last_mc ? 4'h0 : mc_count + 4'h1) : mc_count;
    // One byte per machine cycle, only while bytes remain; a stalled C1 keeps asking
    wire next_fetch = next_state == ICT_C1 && (last_state ?
                      (last_mc || (mc_count + 4'h1) < {2'b00, cur.nbytes}) :
                      state == ICT_C1);
    // Access cycles follow the opcode fetch cycle
    wire next_access = cur.is_movx && next_mc_count != 4'h0;

    wire [3:0] base_mc = ict_cycles(code_byte_i);
    wire is_movx_op = code_byte_i[7:5] == 3'b111 && code_byte_i[3:0] != 4'h1 &&
                      (code_byte_i[3:0] == 4'h0 || code_byte_i[3:1] == 3'b001);
    // Stretch lengthens the access cycle, not the fetch
    wire [3:0] total_mc = is_movx_op ?
                          4'(base_mc + {1'b0, movx_stretch_field}) : base_mc;

    ictpkg_pkg::ict_decode_t next_decode;
    always_comb
    begin
        next_decode = '0;
        next_decode.opcode = code_byte_i;
        next_decode.mcycles = total_mc;
        next_decode.nbytes = ict_bytes(code_byte_i);
        next_decode.is_movx = is_movx_op;
        next_decode.movx_write = code_byte_i[4];
        next_decode.movx_dptr = code_byte_i[1:0] == 2'b00;
        next_decode.reg_sel = code_byte_i[2:0];
        next_decode.ind_sel = code_byte_i[0];
        next_decode.is_abs = code_byte_i[3:0] == 4'h1;
        next_decode.abs_call = code_byte_i[4];
        next_decode.abs_hi = code_byte_i[7:5];
        next_decode.dptr_dec = code_byte_i == ictpkg_pkg::OP_DEC_DPTR;
        next_decode.dptr_sel = pointer_select;
        next_decode.flags = ict_flags(code_byte_i);
    end

    // Four states in strict order, one per clock except C1, which holds while the opcode is not valid
    always_comb
    begin
        case (state)
            ICT_C1: next_state = (mc_count == 4'h0 && !code_valid_i) ? ICT_C1 : ICT_C2;
            ICT_C2: next_state = ICT_C3;
            ICT_C3: next_state = ICT_C4;
            ICT_C4: next_state = ICT_C1;
            default: next_state = ICT_C1;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= ICT_C1;
            cur <= '0;
            mc_count <= 4'h0;
            mc_total <= 4'h1;
        end
        else
        begin
            state <= next_state;
            if (opcode_ok)
            begin
                cur <= next_decode;
                mc_total <= total_mc;
            end
            mc_count <= next_mc_count;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data stand one cycle after the strobe, zero otherwise
    logic [7:0] read_mux;
    always_comb
    begin
        read_mux = 8'h00;
        if (!reg_rd_i)
            read_mux = 8'h00;
        else if (reg_addr_i == ictpkg_pkg::ADDR_CLOCK_CONTROL)
            read_mux = clock_control_sfr;
        else if (reg_addr_i == ictpkg_pkg::ADDR_POINTER_SELECT)
            read_mux = {7'h00, pointer_select};
        else if (reg_addr_i == ictpkg_pkg::ADDR_STATUS)
            read_mux = {mc_count, state};
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            reg_rdata_o <= 8'h00;
        else
            reg_rdata_o <= read_mux;
    end

    ////////////////////////////////////////////////////////////////////
    // Taken from next values so every output lines up with state_o
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            decode_o <= '0;
            state_o <= 4'h1;
            mcycle_o <= 4'h0;
        end
        else
        begin
            decode_o <= opcode_ok ? next_decode : cur;
            state_o <= next_state;
            mcycle_o <= next_mc_count;
        end
    end

    // Strobes; a late one would smear into the next state
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fetch_o <= 1'b0;
            instr_done_o <= 1'b0;
            movx_access_o <= 1'b0;
        end
        else
        begin
            fetch_o <= next_fetch;
            instr_done_o <= finish;
            movx_access_o <= next_access;
        end
    end

endmodule

// >>> pkg/ictpkg_pkg.sv
package ictpkg_pkg;

    // Machine cycle shape
    localparam int STATES_PER_MC = 4;
    localparam int STRETCH_W = 3;

    // Register map of the plain port
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8e;
    localparam logic [7:0] ADDR_POINTER_SELECT = 8'h86;
    localparam logic [7:0] ADDR_STATUS = 8'hf1;
    localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h01;
    localparam logic [7:0] POINTER_SELECT_RESET = 8'h00;
    localparam int STRETCH_LSB = 0;
    localparam int POINTER_SELECT_BIT = 0;

    // Machine cycle counts per class
    localparam logic [3:0] MC_ONE = 4'h1;
    localparam logic [3:0] MC_TWO = 4'h2;
    localparam logic [3:0] MC_THREE = 4'h3;
    localparam logic [3:0] MC_FOUR = 4'h4;
    localparam logic [3:0] MC_FIVE = 4'h5;

    // Selected opcodes
    localparam logic [7:0] OP_DEC_DPTR = 8'ha5;
    localparam logic [7:0] OP_INC_DPTR = 8'ha3;

    // Flag update codes for the datapath
    typedef enum logic [3:0] {
        ICT_FL_NONE = 4'h0,
        ICT_FL_ARITH = 4'h1,   // C, OV, AC from result
        ICT_FL_MULDIV = 4'h2,  // C cleared, OV from result
        ICT_FL_DA = 4'h3,      // C from result only
        ICT_FL_CY_RES = 4'h4,  // C from result only
        ICT_FL_CY_SET = 4'h5,
        ICT_FL_CY_CLR = 4'h6
    } ict_flag_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [3:0] mcycles;
        logic [1:0] nbytes;
        logic is_movx;
        logic movx_write;
        logic movx_dptr;
        logic [2:0] reg_sel;
        logic ind_sel;
        logic is_abs;
        logic abs_call;
        logic [2:0] abs_hi;
        logic dptr_dec;
        logic dptr_sel;
        ict_flag_t flags;
    } ict_decode_t;

endpackage

// >>> bench/ict_sequencer_assertions.sv
`timescale 1ns/1ps
module ict_sequencer_assertions #(
    parameter int STRETCH_W = ictpkg_pkg::STRETCH_W
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Program memory and register port
    input wire logic fetch_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Datapath side
    input wire ictpkg_pkg::ict_decode_t decode_o,
    input wire logic [3:0] state_o,
    input wire logic [3:0] mcycle_o,
    input wire logic instr_done_o,
    input wire logic movx_access_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // C1 may stretch while code is not valid, the rest never does
    sequence c2_to_c1;
        state_o == 4'h2 ##1 state_o == 4'h4 ##1 state_o == 4'h8 ##1 state_o == 4'h1;
    endsequence
    state_onehot_a: assert property ($onehot(state_o))
        else $error("state not one-hot");
    state_order_a: assert property (state_o == 4'h2 |-> c2_to_c1)
        else $error("state order broken");
    c1_leave_a: assert property (state_o == 4'h1 ##1 state_o != 4'h1 |-> state_o == 4'h2)
        else $error("C1 not followed by C2");
    fetch_once_a: assert property (fetch_o ##1 state_o == 4'h2 |-> !fetch_o [*3])
        else $error("extra fetch in cycle");
    fetch_c1_a: assert property (fetch_o |-> state_o == 4'h1)
        else $error("fetch outside C1");
    done_c1_a: assert property (instr_done_o |-> state_o == 4'h1 && mcycle_o == 4'h0)
        else $error("done not at instruction start");
    done_pulse_a: assert property (instr_done_o |-> $past(state_o) == 4'h8 ##1 !instr_done_o)
        else $error("done not after C4");
    mcycle_step_a: assert property ($changed(mcycle_o) |-> state_o == 4'h1)
        else $error("cycle index moved mid cycle");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside slot");
    ptr_read_a: assert property ($past(reg_rd_i) &&
        $past(reg_addr_i) == ictpkg_pkg::ADDR_POINTER_SELECT |-> reg_rdata_o[7:1] == 7'h00)
        else $error("pointer select upper bits set");
    movx_phase_a: assert property (movx_access_o |-> decode_o.is_movx && mcycle_o != 4'h0)
        else $error("data access outside movx");
    abs_decode_a: assert property (decode_o.is_abs |->
        decode_o.abs_hi == decode_o.opcode[7:5] && decode_o.abs_call == decode_o.opcode[4])
        else $error("absolute target bits wrong");
    reg_sel_a: assert property (decode_o.opcode[7:3] == 5'h05 |->
        decode_o.reg_sel == decode_o.opcode[2:0])
        else $error("register select wrong");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ict_sequencer ict_sequencer_assertions #(.STRETCH_W(STRETCH_W)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .fetch_o(fetch_o), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .decode_o(decode_o), .state_o(state_o),
    .mcycle_o(mcycle_o), .instr_done_o(instr_done_o), .movx_access_o(movx_access_o));

// >>> bench/ict_code_mem.sv
`timescale 1ns/1ps
module ict_code_mem (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Bench control
    input wire logic [7:0] opcode_i,
    input wire logic slow_i,
    input wire logic instr_done_i,
    // Code bus
    output logic [7:0] code_byte_o,
    output logic code_valid_o
);
    logic [1:0] gap;
    // Junk byte while stalled so a stale opcode cannot pass
    // Slow mode withholds the very first C1 too, so the stall really bites
    assign code_valid_o = (gap == 2'h0) && !(slow_i && instr_done_i) && !rst_i;
    assign code_byte_o = code_valid_o ? opcode_i : ~opcode_i;
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            gap <= 2'h0;
        else if (slow_i && instr_done_i)
            gap <= 2'h3;
        else if (gap != 2'h0)
            gap <= gap - 2'h1;
    end
endmodule

// >>> bench/instr_cycle_timing_tb_top.sv
`timescale 1ns/1ps
module instr_cycle_timing_tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic slow = 1'b0;
    logic [7:0] code_byte;
    logic code_valid;
    logic fetch;
    logic [7:0] rdata;
    ictpkg_pkg::ict_decode_t dec;
    logic [3:0] state;
    logic [3:0] mcycle;
    logic done;
    logic movx;
    logic [7:0] rnd = 8'h1f;
    logic [7:0] rv;
    int mismatches = 0;
    int check_count = 0;
    int n;
    int m;
    // Opcode, machine cycles, flag code
    logic [15:0] tbl [0:25] = '{16'h0010, 16'h2421, 16'h3421, 16'h9811, 16'ha452, 16'h8452,
        16'hd413, 16'h3314, 16'hb314, 16'hb544, 16'ha224, 16'h8224, 16'h7224, 16'hd315,
        16'hc316, 16'h5330, 16'h2220, 16'h8030, 16'h0240, 16'ha520, 16'ha320, 16'h9030,
        16'h7320, 16'hc020, 16'h6030, 16'h2040};
    ict_sequencer DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .code_byte_i(code_byte),
        .code_valid_i(code_valid), .fetch_o(fetch), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
        .decode_o(dec), .state_o(state), .mcycle_o(mcycle), .instr_done_o(done),
        .movx_access_o(movx));
    ict_code_mem u_mem (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .opcode_i(opcode),
        .slow_i(slow), .instr_done_i(done), .code_byte_o(code_byte), .code_valid_o(code_valid));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic wait_done();
        n = 0;
        m = 0;
        do
        begin
            @(posedge clk_sys_i);
            #1 n++;
            if (movx === 1'b1)
                m++;
            if (n > 300)
            begin
                mismatches++;
                close_out();
            end
        end while (done !== 1'b1);
    endtask
    // From the second interval on it is surely the new opcode back to back; the third is measured
    task automatic run_op(input logic [7:0] op, input logic [3:0] mc);
        @(posedge clk_sys_i);
        opcode <= op;
        repeat (3) wait_done();
        if (slow === 1'b0)
            chk(8'(n), 8'(4 * mc));
        chk(dec.opcode, op);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        chk(8'(state), 8'h01);
        chk(8'(done), 8'h00);
        rst_i <= 1'b0;
        rd(ictpkg_pkg::ADDR_CLOCK_CONTROL);
        chk(8'(rv[2:0]), ictpkg_pkg::CLOCK_CONTROL_RESET);
        rd(ictpkg_pkg::ADDR_POINTER_SELECT);
        chk(rv, ictpkg_pkg::POINTER_SELECT_RESET);
        wr(8'h55, 8'hff);
        rd(8'h55);
        chk(rv, 8'h00);
        foreach (tbl[i])
        begin
            run_op(tbl[i][15:8], tbl[i][7:4]);
            chk(8'(dec.flags), 8'(tbl[i][3:0]));
            chk(8'(dec.dptr_dec), 8'(tbl[i][15:8] == ictpkg_pkg::OP_DEC_DPTR));
        end
        repeat (6)
        begin
            rnd = lfsr(rnd);
            run_op({5'h05, rnd[2:0]}, 4'h1);
            chk(8'(dec.reg_sel), 8'(rnd[2:0]));
            run_op({7'h13, rnd[3]}, 4'h1);
            chk(8'(dec.ind_sel), 8'(rnd[3]));
            run_op({rnd[7:4], 4'h1}, 4'h3);
            chk({dec.is_abs, dec.abs_call, dec.abs_hi, 3'h0}, {1'b1, rnd[4], rnd[7:5], 3'h0});
        end
        for (int p = 0; p < 2; p++)
        begin
            rnd = lfsr(rnd);
            wr(ictpkg_pkg::ADDR_POINTER_SELECT, {1'b1, rnd[6:1], p[0]});
            rd(ictpkg_pkg::ADDR_POINTER_SELECT);
            chk(rv, {7'h00, p[0]});
            run_op(ictpkg_pkg::OP_INC_DPTR, 4'h2);
            chk(8'(dec.dptr_sel), 8'(p[0]));
        end
        for (int s = 0; s < 8; s++)
        begin
            wr(ictpkg_pkg::ADDR_CLOCK_CONTROL, 8'(s));
            rd(ictpkg_pkg::ADDR_CLOCK_CONTROL);
            chk(8'(rv[2:0]), 8'(s));
            run_op(s[0] ? 8'hf3 : 8'he0, 4'(2 + s));
            chk(8'(m), 8'(4 + 4 * s));
            chk(8'({dec.is_movx, dec.movx_write, dec.movx_dptr}), 8'({1'b1, s[0], ~s[0]}));
        end
        // Stalled code memory must stretch the interval, not the decode
        @(posedge clk_sys_i);
        slow <= 1'b1;
        run_op(8'h04, 4'h1);
        chk(8'(n), 8'h08);
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        slow <= 1'b0;
        @(posedge clk_sys_i);
        #1 chk(8'(state), 8'h01);
        @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(ictpkg_pkg::ADDR_CLOCK_CONTROL);
        chk(8'(rv[2:0]), ictpkg_pkg::CLOCK_CONTROL_RESET);
        close_out();
    end
endmodule
